// ===== testbench/pcr_top_properties.sv
`timescale 1ns/100ps
module pcr_top_properties
    import pcr_pkg::*;
#(
    parameter logic [4:0] CAP_LATW = 5'h10,
    parameter logic [2:0] CAP_RND = 3'h2,
    parameter logic CAP_CLFILT = 1'h1
)
(
    input logic clk,
    input logic rst_n,
    input logic fid_req,
    input logic fid_ack_r,
    input pcr_word_t fid_avail_r,
    input pcr_word_t fid_ext_cap_r,
    input pcr_word_t fid_supported_r,
    input logic ext_flag_profiler_r,
    input logic xcw_valid,
    input logic xcw_ack_r,
    input logic xcw_fault_r,
    input logic xstate_enabled_r,
    input logic cb_load_req,
    input logic cb_load_fault_r,
    input logic [63:0] cb_addr_r,
    input logic profiler_active_r,
    input logic [3:0] cb_cache_level_filter,
    input logic [3:0] eff_cache_level_filter_r,
    input logic lat_valid,
    input logic lat_rep_valid_r,
    input logic [31:0] lat_rep_r
);
    localparam logic [31:0] RND_MASK = (32'h1 << CAP_RND) - 32'h1;
    localparam logic [31:0] LAT_MAX = (32'h1 << CAP_LATW) - 32'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    query_answer_a: assert property (fid_req |=> fid_ack_r)
        else $error("feature query not answered");
    words_hold_a: assert property (!fid_req |=> $stable(fid_ext_cap_r) && $stable(fid_supported_r))
        else $error("capability words moved without a query");
    reserved_zero_a: assert property (fid_supported_r[28:7] == 22'h0 && fid_ext_cap_r[27:24] == 4'h0)
        else $error("reserved capability bits set");
    avail_subset_a: assert property ((fid_avail_r[31:1] & ~fid_supported_r[31:1]) == 31'h0)
        else $error("available bits exceed supported bits");
    avail_enable_a: assert property (fid_ack_r && $stable(xstate_enabled_r)
        |-> fid_avail_r[0] == (xstate_enabled_r && ext_flag_profiler_r))
        else $error("available bit does not follow enable bit");
    latency_range_a: assert property (fid_ack_r && fid_supported_r[4]
        |-> fid_ext_cap_r[4:0] >= 5'h0a && fid_ext_cap_r[8:6] <= 3'h4)
        else $error("latency width or rounding out of range");
    no_miss_zero_a: assert property (fid_ack_r && !fid_supported_r[4]
        |-> fid_ext_cap_r[8:0] == 9'h0 && fid_ext_cap_r[31:30] == 2'h0)
        else $error("latency fields set without miss event");
    one_filter_a: assert property (fid_ack_r && fid_supported_r[4] |-> fid_ext_cap_r[31] || fid_ext_cap_r[30])
        else $error("no cache filter with miss event");
    version_one_a: assert property (fid_ack_r && fid_supported_r[0] |-> fid_ext_cap_r[15:9] == 7'h01)
        else $error("version field not one");
    enable_start_a: assert property ($rose(xstate_enabled_r) |-> cb_addr_r == 64'h0 && !profiler_active_r)
        else $error("profiler not idle after enable");
    refuse_load_a: assert property (cb_load_req && !xstate_enabled_r && !xcw_valid
        |=> cb_load_fault_r && $stable(cb_addr_r))
        else $error("control block load accepted while disabled");
    xstate_answer_a: assert property (xcw_valid |=> xcw_ack_r || xcw_fault_r)
        else $error("enable mask write not answered");
    lat_round_a: assert property (lat_valid |=> lat_rep_valid_r && (lat_rep_r & RND_MASK) == 32'h0
        && lat_rep_r <= LAT_MAX)
        else $error("latency report not rounded or clamped");
    level_gate_a: assert property (1'b1 |=> eff_cache_level_filter_r
        == ($past(cb_cache_level_filter) & {4{CAP_CLFILT}}))
        else $error("cache level filter not gated");

    cover property (fid_ack_r && fid_avail_r[0]);
    cover property (cb_load_fault_r);
    cover property ($rose(xstate_enabled_r));
    cover property (lat_rep_valid_r && lat_rep_r == (LAT_MAX & ~RND_MASK));
endmodule // pcr_top_properties

// ===== testbench/pcr_top_tb.sv
`timescale 1ns/100ps
`include "pcr_regs.svh"
module pcr_top_tb
    import pcr_pkg::*;
;
    localparam logic [31:0] CFG_OK = 32'he000007e;
    localparam logic [31:0] A_CFG = `PCR_MSR_CFG_ADDR;
    localparam logic [31:0] A_CB = `PCR_MSR_CBADDR_ADDR;
    logic clk = 1'b0, rst_n = 1'b0, fid_req = 1'b0, xcw_valid = 1'b0, xcw_bit62 = 1'b0;
    logic msr_req = 1'b0, msr_write = 1'b0, cb_load_req = 1'b0, lat_valid = 1'b0;
    logic [31:0] msr_addr = 32'h0, lat_raw = 32'h0, cb_min_lat = 32'h0;
    logic [63:0] msr_wdata = 64'h0, cb_load_addr = 64'h0, rd, w, a;
    logic cb_mp = 1'b0, cb_pp = 1'b0, cb_pe = 1'b0, cb_pi = 1'b0;
    logic [3:0] cb_lvl = 4'h0;
    logic fid_ack_r, ext_flag_profiler_r, xcw_ack_r, xcw_fault_r, xstate_enabled_r;
    logic msr_ack_r, msr_fault_r, cb_load_ack_r, cb_load_fault_r, profiler_active_r, lat_rep_valid_r;
    logic eff_mp, eff_pp, eff_pe, eff_pi;
    logic [3:0] eff_lvl;
    logic [31:0] eff_min_lat, lat_rep_r, r;
    logic [63:0] msr_rdata_r, cb_addr_r;
    pcr_word_t fid_avail_r, fid_ext_cap_r, fid_supported_r;
    int checks = 0, fail_count = 0;

    always #2 clk = ~clk;

    pcr_top dut (
        .clk(clk), .rst_n(rst_n), .fid_req(fid_req), .fid_ack_r(fid_ack_r), .fid_avail_r(fid_avail_r),
        .fid_ext_cap_r(fid_ext_cap_r), .fid_supported_r(fid_supported_r), .ext_flag_profiler_r(ext_flag_profiler_r),
        .xcw_valid(xcw_valid), .xcw_bit62(xcw_bit62), .xcw_ack_r(xcw_ack_r),
        .xcw_fault_r(xcw_fault_r), .xstate_enabled_r(xstate_enabled_r), .msr_req(msr_req),
        .msr_write(msr_write), .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack_r(msr_ack_r),
        .msr_fault_r(msr_fault_r), .msr_rdata_r(msr_rdata_r), .cb_load_req(cb_load_req),
        .cb_load_addr(cb_load_addr), .cb_load_ack_r(cb_load_ack_r), .cb_load_fault_r(cb_load_fault_r),
        .cb_addr_r(cb_addr_r), .profiler_active_r(profiler_active_r), .cb_mispredicted_filter(cb_mp),
        .cb_predicted_filter(cb_pp), .cb_pointer_filter_enable(cb_pe), .cb_pointer_filter_invert(cb_pi),
        .cb_cache_level_filter(cb_lvl), .cb_minimum_latency_filter(cb_min_lat),
        .eff_mispredicted_filter_r(eff_mp), .eff_predicted_filter_r(eff_pp),
        .eff_pointer_filter_enable_r(eff_pe), .eff_pointer_filter_invert_r(eff_pi),
        .eff_cache_level_filter_r(eff_lvl), .eff_minimum_latency_filter_r(eff_min_lat),
        .lat_valid(lat_valid), .lat_raw(lat_raw), .lat_rep_valid_r(lat_rep_valid_r), .lat_rep_r(lat_rep_r)
    );

    function automatic pcr_word_t exp_ext();
        return {`PCR_DEF_LATFILT, `PCR_DEF_CLFILT, `PCR_DEF_IPFILT, `PCR_DEF_BRPRED, 4'h0, `PCR_DEF_MINBUF,
            `PCR_VERSION, `PCR_DEF_RND, `PCR_DEF_DADDR, `PCR_DEF_LATW};
    endfunction

    function automatic pcr_word_t exp_sup();
        return {`PCR_DEF_INT, `PCR_DEF_PTSC, `PCR_DEF_CONT, 22'h0, `PCR_DEF_EVENTS, `PCR_DEF_PRESENT};
    endfunction

    function automatic logic [31:0] exp_lat(input logic [31:0] raw);
        logic [31:0] lmax;
        lmax = (32'h1 << `PCR_DEF_LATW) - 32'h1;
        return ((raw > lmax) ? lmax : raw) & ~((32'h1 << `PCR_DEF_RND) - 32'h1);
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic fid();
        @(posedge clk) fid_req <= 1'b1;
        @(posedge clk) fid_req <= 1'b0;
        #1 chk(fid_ack_r, 1'b1);
    endtask

    task automatic msr(input logic wr, input logic [31:0] ad, input logic [63:0] wd, input logic flt);
        @(posedge clk) begin
            msr_req <= 1'b1;
            msr_write <= wr;
            msr_addr <= ad;
            msr_wdata <= wd;
        end
        @(posedge clk) msr_req <= 1'b0;
        #1 chk(msr_ack_r, 1'b1);
        chk(msr_fault_r, flt);
        rd = msr_rdata_r;
    endtask

    task automatic xset(input logic b);
        @(posedge clk) begin
            xcw_valid <= 1'b1;
            xcw_bit62 <= b;
        end
        @(posedge clk) xcw_valid <= 1'b0;
        #1 chk(xstate_enabled_r, b);
        chk({xcw_ack_r, xcw_fault_r}, 2'h2);
        chk(cb_addr_r, 64'h0);
        chk(profiler_active_r, 1'b0);
    endtask

    task automatic load(input logic [63:0] ad, input logic flt, input logic [63:0] ea);
        @(posedge clk) begin
            cb_load_req <= 1'b1;
            cb_load_addr <= ad;
        end
        @(posedge clk) cb_load_req <= 1'b0;
        #1 chk(cb_load_fault_r, flt);
        chk(cb_load_ack_r, 1'b1);
        chk(cb_addr_r, ea);
    endtask

    initial begin
        r = $urandom(72);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        fid();
        chk(fid_ext_cap_r, exp_ext());
        chk(fid_supported_r, exp_sup());
        chk(fid_avail_r, 32'h0);
        chk(ext_flag_profiler_r, 1'b1);
        load(64'h1000, 1'b1, 64'h0);
        msr(1'b0, A_CB, 64'h0, 1'b1);
        xset(1'b1);
        fid();
        chk(fid_avail_r, 32'h1);
        msr(1'b1, A_CB, 64'h40, 1'b1);
        msr(1'b0, 32'hc000_0107, 64'h0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            w = {16'h0, 16'($urandom()), $urandom() & CFG_OK};
            msr(1'b1, A_CFG, w, 1'b0);
            msr(1'b0, A_CFG, 64'h0, 1'b0);
            chk(rd, w);
            fid();
            chk(fid_avail_r, {w[31:1], 1'b1});
        end
        for (int k = 0; k < 3; k++) begin
            msr(1'b1, A_CFG, w | (64'h1 << ((k == 0) ? 0 : (k == 1) ? 7 : 48)), 1'b1);
            msr(1'b0, A_CFG, 64'h0, 1'b0);
            chk(rd, w);
        end
        a = {$urandom(), $urandom()} | 64'h8;
        load(a, 1'b0, a);
        chk(profiler_active_r, 1'b1);
        msr(1'b0, A_CB, 64'h0, 1'b0);
        chk(rd, a);
        xset(1'b0);
        xset(1'b1);
        for (int i = 0; i < 20; i++) begin
            r = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_ffff : (i == 2) ? 32'h3 : $urandom();
            @(posedge clk) begin
                lat_valid <= 1'b1;
                lat_raw <= r;
                cb_lvl <= 4'($urandom());
                cb_min_lat <= $urandom();
                {cb_mp, cb_pp, cb_pe, cb_pi} <= 4'($urandom());
            end
            @(posedge clk) lat_valid <= 1'b0;
            #1 chk(lat_rep_r, exp_lat(r));
            chk(eff_lvl, cb_lvl);
            chk(eff_min_lat, cb_min_lat);
            chk({eff_mp, eff_pp}, {cb_mp, cb_pp});
            chk({eff_pe, eff_pi}, {cb_pe, cb_pi});
        end
        stop_test();
    end

    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule // pcr_top_tb

bind pcr_top pcr_top_properties #(.CAP_LATW(CAP_LATW), .CAP_RND(CAP_RND), .CAP_CLFILT(CAP_CLFILT)) chk_i (
    .clk(clk), .rst_n(rst_n), .fid_req(fid_req), .fid_ack_r(fid_ack_r), .fid_avail_r(fid_avail_r),
    .fid_ext_cap_r(fid_ext_cap_r), .fid_supported_r(fid_supported_r), .ext_flag_profiler_r(ext_flag_profiler_r),
    .xcw_valid(xcw_valid), .xcw_ack_r(xcw_ack_r), .xcw_fault_r(xcw_fault_r),
    .xstate_enabled_r(xstate_enabled_r), .cb_load_req(cb_load_req), .cb_load_fault_r(cb_load_fault_r),
    .cb_addr_r(cb_addr_r), .profiler_active_r(profiler_active_r), .cb_cache_level_filter(cb_cache_level_filter),
    .eff_cache_level_filter_r(eff_cache_level_filter_r), .lat_valid(lat_valid),
    .lat_rep_valid_r(lat_rep_valid_r), .lat_rep_r(lat_rep_r)
);

// ===== verilog/pcr_ext_cap.sv
`timescale 1ns/100ps
`include "pcr_regs.svh"
module pcr_ext_cap
    import pcr_pkg::*;
(
    input wire logic dcache_miss_cap,
    input wire logic branch_retired_cap,
    input wire logic [4:0] latency_counter_width,
    input wire logic miss_data_addr_reported,
    input wire logic [2:0] latency_rounding_bits,
    input wire logic [7:0] min_ring_records,
    input wire logic branch_pred_filter_cap,
    input wire logic ip_range_filter_cap,
    input wire logic cache_level_filter_cap,
    input wire logic latency_filter_cap,
    output pcr_word_t ext_word
);
    logic [4:0] latw;
    logic [2:0] rnd;
    logic cache_level_filter;

    always_comb begin
        latw = (latency_counter_width < `PCR_LATW_MIN) ? `PCR_LATW_MIN : latency_counter_width; // RQ1
        rnd = (latency_rounding_bits > `PCR_RND_MAX) ? `PCR_RND_MAX : latency_rounding_bits; // RQ4
        // with neither filter asked for, cache level filtering is forced on
        cache_level_filter = cache_level_filter_cap | ~latency_filter_cap; // RQ11
        ext_word = `PCR_WORD_RESET; // RQ20
        ext_word[`PCR_EXT_VER_MSB:`PCR_EXT_VER_LSB] = `PCR_VERSION; // RQ5
        ext_word[`PCR_EXT_MINBUF_MSB:`PCR_EXT_MINBUF_LSB] = min_ring_records; // RQ6
        ext_word[`PCR_EXT_BRPRED_BIT] = branch_pred_filter_cap & branch_retired_cap; // RQ7
        ext_word[`PCR_EXT_IPFILT_BIT] = ip_range_filter_cap; // RQ8
        if (dcache_miss_cap) begin // RQ2
            ext_word[`PCR_EXT_LATW_MSB:`PCR_EXT_LATW_LSB] = latw; // RQ1
            ext_word[`PCR_EXT_DADDR_BIT] = miss_data_addr_reported; // RQ3
            ext_word[`PCR_EXT_RND_MSB:`PCR_EXT_RND_LSB] = rnd; // RQ4
            ext_word[`PCR_EXT_CLFILT_BIT] = cache_level_filter; // RQ9
            ext_word[`PCR_EXT_LATFILT_BIT] = latency_filter_cap; // RQ10
        end
    end
endmodule // pcr_ext_cap

// ===== verilog/pcr_feat_word.sv
`timescale 1ns/100ps
`include "pcr_regs.svh"
module pcr_feat_word
    import pcr_pkg::*;
(
    input wire logic profiler_present,
    input wire logic [5:0] event_caps,
    input wire logic continuous_mode_cap,
    input wire logic record_timestamp_cap,
    input wire logic threshold_irq_cap,
    input wire logic [`PCR_CFG_MSB:0] cfg_bits,
    input wire logic xstate_enabled,
    output pcr_word_t supported_word,
    output pcr_word_t avail_word
);
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            if (i == `PCR_SUP_PRESENT_BIT) begin : g_present
                assign supported_word[i] = profiler_present; // RQ12
                assign avail_word[i] = xstate_enabled & profiler_present; // RQ18
            end else begin : g_feat
                logic cap;
                if (i >= `PCR_SUP_EVT_LSB && i <= `PCR_SUP_EVT_MSB) begin : g_evt
                    assign cap = event_caps[i - `PCR_SUP_EVT_LSB]; // RQ13
                end else if (i == `PCR_SUP_CONT_BIT) begin : g_cont
                    assign cap = continuous_mode_cap; // RQ14
                end else if (i == `PCR_SUP_PTSC_BIT) begin : g_ptsc
                    assign cap = record_timestamp_cap; // RQ14
                end else if (i == `PCR_SUP_INT_BIT) begin : g_int
                    assign cap = threshold_irq_cap; // RQ14
                end else begin : g_rsvd
                    assign cap = 1'b0; // RQ20
                end
                assign supported_word[i] = cap & profiler_present;
                assign avail_word[i] = cfg_bits[i] & cap & profiler_present; // RQ19
            end
        end
    endgenerate
endmodule // pcr_feat_word

// ===== verilog/pcr_pkg.sv
package pcr_pkg;
    typedef logic [31:0] pcr_word_t;
    typedef enum logic [1:0] {PCR_MSR_NONE, PCR_MSR_CFG, PCR_MSR_CBADDR} pcr_msr_sel_t;
endpackage

// ===== verilog/pcr_regs.svh
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// extended capability word fields
`define PCR_EXT_LATW_LSB 0
`define PCR_EXT_LATW_MSB 4
`define PCR_EXT_DADDR_BIT 5
`define PCR_EXT_RND_LSB 6
`define PCR_EXT_RND_MSB 8
`define PCR_EXT_VER_LSB 9
`define PCR_EXT_VER_MSB 15
`define PCR_EXT_MINBUF_LSB 16
`define PCR_EXT_MINBUF_MSB 23
`define PCR_EXT_BRPRED_BIT 28
`define PCR_EXT_IPFILT_BIT 29
`define PCR_EXT_CLFILT_BIT 30
`define PCR_EXT_LATFILT_BIT 31

// supported / available feature word fields
`define PCR_SUP_PRESENT_BIT 0
`define PCR_SUP_EVT_LSB 1
`define PCR_SUP_EVT_MSB 6
`define PCR_SUP_BRE_BIT 3
`define PCR_SUP_DME_BIT 4
`define PCR_SUP_CONT_BIT 29
`define PCR_SUP_PTSC_BIT 30
`define PCR_SUP_INT_BIT 31

// fixed figures
`define PCR_LATW_MIN 5'h0a
`define PCR_RND_MAX 3'h4
`define PCR_VERSION 7'h01
`define PCR_XSTATE_BIT 62

// model-specific register map
`define PCR_MSR_CFG_ADDR 32'hc000_0105
`define PCR_MSR_CBADDR_ADDR 32'hc000_0106
`define PCR_CFG_MSB 47
`define PCR_CFG_RESET 48'h0000_0000_0000
`define PCR_CBADDR_RESET 64'h0000_0000_0000_0000
`define PCR_WORD_RESET 32'h0000_0000

// capability defaults
`define PCR_DEF_PRESENT 1'h1
`define PCR_DEF_EVENTS 6'h3f
`define PCR_DEF_CONT 1'h1
`define PCR_DEF_PTSC 1'h1
`define PCR_DEF_INT 1'h1
`define PCR_DEF_LATW 5'h10
`define PCR_DEF_DADDR 1'h1
`define PCR_DEF_RND 3'h2
`define PCR_DEF_MINBUF 8'h01
`define PCR_DEF_BRPRED 1'h1
`define PCR_DEF_IPFILT 1'h1
`define PCR_DEF_CLFILT 1'h1
`define PCR_DEF_LATFILT 1'h1

`endif

// ===== verilog/pcr_top.sv
// Notes on behaviour
// RQ1 - latency counter width sits in bits 4:0, kept within 10 to 31
// RQ2 - without data cache miss support all latency and cache fields read zero
// RQ3 - bit 5 says whether miss records carry the data address
// RQ4 - bits 8:6 give latency rounding 0 to 4; low bits of latency read zero
// RQ5 - bits 15:9 hold implementation version, one for the first version
// RQ6 - bits 23:16 give minimum ring size in 32-record units; zero means none
// RQ7 - bit 28 flags prediction filtering; otherwise those filter fields are ignored
// RQ8 - bit 29 flags pointer range filtering; otherwise its fields are ignored
// RQ9 - bit 30 flags cache level filtering; otherwise the level field is ignored
// RQ10 - bit 31 flags latency filtering; otherwise minimum latency is ignored
// RQ11 - with cache events supported at least one of the two filters exists
// RQ12 - supported word bit 0 mirrors the profiler flag; zero voids the rest
// RQ13 - supported word bits 1 to 6 flag event identifiers 1 to 6
// RQ14 - bits 29 to 31 flag continuous mode, timestamps, threshold interrupt
// RQ15 - profiler model-specific registers exist only when the profiler flag is set
// RQ16 - profiler use is refused while extended state enable bit 62 is clear
// RQ17 - setting the enable bit leaves the profiler disabled, control block address zero
// RQ18 - available word bit 0 copies enable bit 62
// RQ19 - available word bits 31:1 come from configuration, a subset of supported
// RQ20 - reserved bits of both capability words always read zero
`timescale 1ns/100ps
`include "pcr_regs.svh"
module pcr_top
    import pcr_pkg::*;
#(
    parameter logic CAP_PRESENT = `PCR_DEF_PRESENT,
    parameter logic [5:0] CAP_EVENTS = `PCR_DEF_EVENTS,
    parameter logic CAP_CONT = `PCR_DEF_CONT,
    parameter logic CAP_PTSC = `PCR_DEF_PTSC,
    parameter logic CAP_INT = `PCR_DEF_INT,
    parameter logic [4:0] CAP_LATW = `PCR_DEF_LATW,
    parameter logic CAP_DADDR = `PCR_DEF_DADDR,
    parameter logic [2:0] CAP_RND = `PCR_DEF_RND,
    parameter logic [7:0] CAP_MINBUF = `PCR_DEF_MINBUF,
    parameter logic CAP_BRPRED = `PCR_DEF_BRPRED,
    parameter logic CAP_IPFILT = `PCR_DEF_IPFILT,
    parameter logic CAP_CLFILT = `PCR_DEF_CLFILT,
    parameter logic CAP_LATFILT = `PCR_DEF_LATFILT
)
(
    input wire logic clk,
    input wire logic rst_n,

    // feature identification query
    input wire logic fid_req,
    output logic fid_ack_r,
    output pcr_word_t fid_avail_r,
    output pcr_word_t fid_ext_cap_r,
    output pcr_word_t fid_supported_r,
    output logic ext_flag_profiler_r,

    // extended control write
    input wire logic xcw_valid,
    input wire logic xcw_bit62,
    output logic xcw_ack_r,
    output logic xcw_fault_r,
    output logic xstate_enabled_r,

    // model-specific register access
    input wire logic msr_req,
    input wire logic msr_write,
    input wire logic [31:0] msr_addr,
    input wire logic [63:0] msr_wdata,
    output logic msr_ack_r,
    output logic msr_fault_r,
    output logic [63:0] msr_rdata_r,

    // control block load
    input wire logic cb_load_req,
    input wire logic [63:0] cb_load_addr,
    output logic cb_load_ack_r,
    output logic cb_load_fault_r,
    output logic [63:0] cb_addr_r,
    output logic profiler_active_r,

    // control block filter fields
    input wire logic cb_mispredicted_filter,
    input wire logic cb_predicted_filter,
    input wire logic cb_pointer_filter_enable,
    input wire logic cb_pointer_filter_invert,
    input wire logic [3:0] cb_cache_level_filter,
    input wire logic [31:0] cb_minimum_latency_filter,
    output logic eff_mispredicted_filter_r,
    output logic eff_predicted_filter_r,
    output logic eff_pointer_filter_enable_r,
    output logic eff_pointer_filter_invert_r,
    output logic [3:0] eff_cache_level_filter_r,
    output logic [31:0] eff_minimum_latency_filter_r,

    // latency reporting
    input wire logic lat_valid,
    input wire logic [31:0] lat_raw,
    output logic lat_rep_valid_r,
    output logic [31:0] lat_rep_r
);
    pcr_word_t ext_word;
    pcr_word_t supported_word;
    pcr_word_t avail_word;

    logic [`PCR_CFG_MSB:0] cfg_r;
    logic [`PCR_CFG_MSB:0] cfg_nxt;
    logic [63:0] cb_addr_nxt;
    logic xstate_nxt;
    pcr_msr_sel_t msr_sel;
    logic msr_refuse;
    logic cfg_illegal;

    logic [4:0] latw;
    logic [2:0] rnd;
    logic [31:0] lat_max;
    logic [31:0] lat_mask;
    logic [31:0] lat_sat;

    pcr_ext_cap u_ext_cap (
        .dcache_miss_cap(CAP_EVENTS[`PCR_SUP_DME_BIT - `PCR_SUP_EVT_LSB]),
        .branch_retired_cap(CAP_EVENTS[`PCR_SUP_BRE_BIT - `PCR_SUP_EVT_LSB]),
        .latency_counter_width(CAP_LATW),
        .miss_data_addr_reported(CAP_DADDR),
        .latency_rounding_bits(CAP_RND),
        .min_ring_records(CAP_MINBUF),
        .branch_pred_filter_cap(CAP_BRPRED),
        .ip_range_filter_cap(CAP_IPFILT),
        .cache_level_filter_cap(CAP_CLFILT),
        .latency_filter_cap(CAP_LATFILT),
        .ext_word(ext_word)
    );

    pcr_feat_word u_feat_word (
        .profiler_present(CAP_PRESENT),
        .event_caps(CAP_EVENTS),
        .continuous_mode_cap(CAP_CONT),
        .record_timestamp_cap(CAP_PTSC),
        .threshold_irq_cap(CAP_INT),
        .cfg_bits(cfg_r),
        .xstate_enabled(xstate_enabled_r),
        .supported_word(supported_word),
        .avail_word(avail_word)
    );

    // msr decode and legality
    always_comb begin
        msr_sel = PCR_MSR_NONE;
        if (msr_addr == `PCR_MSR_CFG_ADDR) begin
            msr_sel = PCR_MSR_CFG;
        end else if (msr_addr == `PCR_MSR_CBADDR_ADDR) begin
            msr_sel = PCR_MSR_CBADDR;
        end
        // bit 0 and bits above the vector field are reserved; feature bits must be supported
        cfg_illegal = (msr_wdata[31:1] & ~supported_word[31:1]) != 31'h0000_0000; // RQ19
        cfg_illegal = cfg_illegal | msr_wdata[0] | (msr_wdata[63:`PCR_CFG_MSB + 1] != 16'h0000);
        msr_refuse = 1'b0;
        unique case (msr_sel)
            PCR_MSR_NONE: msr_refuse = 1'b1;
            PCR_MSR_CFG: msr_refuse = msr_write & cfg_illegal;
            PCR_MSR_CBADDR: msr_refuse = msr_write | ~xstate_enabled_r; // RQ16
        endcase
        if (!CAP_PRESENT) begin
            msr_refuse = 1'b1; // RQ15
        end
    end

    always_comb begin
        cfg_nxt = cfg_r;
        // a refused write leaves the register as it was
        if (msr_req && msr_write && msr_sel == PCR_MSR_CFG && !msr_refuse) begin
            cfg_nxt = msr_wdata[`PCR_CFG_MSB:0]; // RQ19
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `PCR_CFG_RESET;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msr_ack_r <= 1'b0;
            msr_fault_r <= 1'b0;
            msr_rdata_r <= 64'h0000_0000_0000_0000;
        end else begin
            msr_ack_r <= msr_req;
            msr_fault_r <= msr_req & msr_refuse;
            if (msr_req && !msr_write && !msr_refuse) begin
                if (msr_sel == PCR_MSR_CFG) begin
                    msr_rdata_r <= {16'h0000, cfg_r};
                end else begin
                    msr_rdata_r <= cb_addr_r;
                end
            end else if (msr_req) begin
                // writes and refused reads return zero
                msr_rdata_r <= 64'h0000_0000_0000_0000;
            end
        end
    end

    // extended state enable bit; setting it on an absent profiler is refused
    always_comb begin
        xstate_nxt = xstate_enabled_r;
        if (xcw_valid && !(xcw_bit62 && !CAP_PRESENT)) begin
            xstate_nxt = xcw_bit62; // RQ16
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xstate_enabled_r <= 1'b0;
            xcw_ack_r <= 1'b0;
            xcw_fault_r <= 1'b0;
        end else begin
            xstate_enabled_r <= xstate_nxt;
            xcw_ack_r <= xcw_valid;
            xcw_fault_r <= xcw_valid & xcw_bit62 & ~CAP_PRESENT; // RQ15
        end
    end

    // control block address; any change of the enable bit starts the profiler disabled
    always_comb begin
        cb_addr_nxt = cb_addr_r;
        if (xstate_nxt != xstate_enabled_r) begin
            cb_addr_nxt = `PCR_CBADDR_RESET; // RQ17
        end else if (cb_load_req && xstate_enabled_r) begin
            cb_addr_nxt = cb_load_addr; // RQ16
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cb_addr_r <= `PCR_CBADDR_RESET;
            profiler_active_r <= 1'b0;
            cb_load_ack_r <= 1'b0;
            cb_load_fault_r <= 1'b0;
        end else begin
            cb_addr_r <= cb_addr_nxt;
            profiler_active_r <= xstate_nxt & (cb_addr_nxt != `PCR_CBADDR_RESET); // RQ17
            cb_load_ack_r <= cb_load_req;
            cb_load_fault_r <= cb_load_req & ~xstate_enabled_r; // RQ16
        end
    end

    // feature identification answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fid_ack_r <= 1'b0;
            fid_avail_r <= `PCR_WORD_RESET;
            fid_ext_cap_r <= `PCR_WORD_RESET;
            fid_supported_r <= `PCR_WORD_RESET;
            ext_flag_profiler_r <= 1'b0;
        end else begin
            fid_ack_r <= fid_req;
            ext_flag_profiler_r <= CAP_PRESENT; // RQ12
            // words are captured on a query and held until the next
            if (fid_req) begin
                fid_avail_r <= avail_word; // RQ18
                fid_ext_cap_r <= ext_word; // RQ1
                fid_supported_r <= supported_word; // RQ13
            end
        end
    end

    // control block fields pass only where the matching capability exists
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_mispredicted_filter_r <= 1'b0;
            eff_predicted_filter_r <= 1'b0;
            eff_pointer_filter_enable_r <= 1'b0;
            eff_pointer_filter_invert_r <= 1'b0;
            eff_cache_level_filter_r <= 4'h0;
            eff_minimum_latency_filter_r <= 32'h0000_0000;
        end else begin
            eff_mispredicted_filter_r <= cb_mispredicted_filter & ext_word[`PCR_EXT_BRPRED_BIT]; // RQ7
            eff_predicted_filter_r <= cb_predicted_filter & ext_word[`PCR_EXT_BRPRED_BIT]; // RQ7
            eff_pointer_filter_enable_r <= cb_pointer_filter_enable & ext_word[`PCR_EXT_IPFILT_BIT]; // RQ8
            eff_pointer_filter_invert_r <= cb_pointer_filter_invert & ext_word[`PCR_EXT_IPFILT_BIT]; // RQ8
            eff_cache_level_filter_r <= ext_word[`PCR_EXT_CLFILT_BIT] ? cb_cache_level_filter : 4'h0; // RQ9
            eff_minimum_latency_filter_r <= ext_word[`PCR_EXT_LATFILT_BIT] ? cb_minimum_latency_filter
                                                                            : 32'h0000_0000; // RQ10
        end
    end

    // latency saturates at the counter width, low rounding bits forced to zero
    always_comb begin
        latw = ext_word[`PCR_EXT_LATW_MSB:`PCR_EXT_LATW_LSB];
        rnd = ext_word[`PCR_EXT_RND_MSB:`PCR_EXT_RND_LSB];
        // no miss support gives a zero width and so a zero ceiling
        lat_max = 32'hffff_ffff >> (6'h20 - {1'b0, latw}); // RQ1
        lat_mask = 32'hffff_ffff << rnd; // RQ4
        lat_sat = (lat_raw > lat_max) ? lat_max : lat_raw;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_rep_valid_r <= 1'b0;
            lat_rep_r <= 32'h0000_0000;
        end else begin
            lat_rep_valid_r <= lat_valid;
            if (lat_valid) begin
                lat_rep_r <= lat_sat & lat_mask; // RQ4
            end
        end
    end
endmodule // pcr_top
